// ### motrep_defs.vh
// Constants for the motion report register block
// What this block does
// - Read-only 8-bit silicon revision register, separate from firmware version.
// - Status bit 7 set when unreported motion waits in either axis accumulator.
// - Status bit 5 shows whether both low-power config values are complements.
// - Status bit 4 set when an axis buffer overflowed since last report.
// - Status bit 1 set while bias or laser drive pin short is seen.
// - Status bit 0 shows resolution: 0 for 400 cpi, 1 for 800.
// - Status read freezes X and Y deltas for the following delta reads.
// - Second status read before delta reads discards previously frozen deltas.
// - Each axis accumulates beyond eight bits; buffer overflow sets overflow flag.
// - Overflow flag clears on delta read if no axis sits at full scale.
// - Residual motion shows as full scale deltas until motion bit clears.
// - Saturated buffer drains in 16 reads at low, 32 at high resolution.
// - Any write to motion clear discards all earlier motion on both axes; motion added in the same cycle is kept.
// - X delta is signed 8-bit count since last report, cleared on read.
// - Y delta is signed 8-bit count since last report, cleared on read.
// - Registers are reached through the serial port register access.
`ifndef MOTREP_DEFS_VH
`define MOTREP_DEFS_VH

`define MR_ADDR_W 7
`define MR_ADDR_REVISION 7'h01
`define MR_ADDR_STATUS 7'h02
`define MR_ADDR_DELTA_X 7'h03
`define MR_ADDR_DELTA_Y 7'h04
`define MR_ADDR_MOTION_CLEAR 7'h12

`define MR_BIT_MOVED 7
`define MR_BIT_LP_OK 5
`define MR_BIT_OVERFLOW 4
`define MR_BIT_FAULT 1
`define MR_BIT_RES 0

`define MR_STATUS_RESET 8'h00
`define MR_DELTA_RESET 8'h00
`define MR_READ_ZERO 8'h00

`define MR_ACC_W 13
`define MR_LIM_POS_LO 13'h07f0
`define MR_LIM_NEG_LO 13'h1800
`define MR_LIM_POS_HI 13'h0fe0
`define MR_LIM_NEG_HI 13'h1000
`define MR_DELTA_POS_FS 8'h7f
`define MR_DELTA_NEG_FS 8'h80

`define MR_FAULT_FILT 4

`endif

// ### motrep_axis.v
// One axis motion accumulator with saturation and report take-out
`timescale 1ns/1ps
`include "motrep_defs.vh"
module motrep_axis #(
   parameter ACC_W = `MR_ACC_W
)(
   input wire clk_sys_in,
   input wire rst_b_in,
   input wire add_valid_in,
   input wire [7:0] add_delta_in,
   input wire high_res_in,
   input wire clear_in,
   input wire take_in,
   output wire [7:0] take_delta_out,
   output wire nonzero_out,
   output wire full_scale_out,
   output reg overflow_out
);
   localparam [ACC_W-1:0] P127 = {{(ACC_W-8){1'b0}}, 8'h7f};
   localparam [ACC_W-1:0] N128 = {{(ACC_W-8){1'b1}}, 8'h80};
   reg [ACC_W-1:0] acc;
   reg [ACC_W-1:0] next_acc;
   reg [ACC_W+1:0] sum;
   reg next_ovf;
   wire [ACC_W-1:0] lim_pos;
   wire [ACC_W-1:0] lim_neg;
   wire [ACC_W+1:0] add_ext;
   wire [ACC_W+1:0] take_ext;

   function [7:0] clamp8;
      input [ACC_W-1:0] v;
      begin
         if ($signed(v) > $signed(P127))
            clamp8 = `MR_DELTA_POS_FS;
         else if ($signed(v) < $signed(N128))
            clamp8 = `MR_DELTA_NEG_FS;
         else
            clamp8 = v[7:0];
      end
   endfunction

   assign lim_pos = high_res_in ? `MR_LIM_POS_HI : `MR_LIM_POS_LO;
   assign lim_neg = high_res_in ? `MR_LIM_NEG_HI : `MR_LIM_NEG_LO;
   assign take_delta_out = clamp8(acc);
   assign nonzero_out = |acc;
   assign full_scale_out = (acc == lim_pos) || (acc == lim_neg);
   assign add_ext = add_valid_in ?
      {{(ACC_W-6){add_delta_in[7]}}, add_delta_in} : {(ACC_W+2){1'b0}};
   assign take_ext = take_in ?
      {{(ACC_W-6){take_delta_out[7]}}, take_delta_out} : {(ACC_W+2){1'b0}};

   always @*
   begin
      next_ovf = 1'b0;
      if (clear_in)
         sum = add_ext;
      else
         sum = {{2{acc[ACC_W-1]}}, acc} - take_ext + add_ext;
      if ($signed(sum) > $signed({{2{lim_pos[ACC_W-1]}}, lim_pos}))
      begin
         next_acc = lim_pos;
         next_ovf = 1'b1;
      end
      else if ($signed(sum) < $signed({{2{lim_neg[ACC_W-1]}}, lim_neg}))
      begin
         next_acc = lim_neg;
         next_ovf = 1'b1;
      end
      else
         next_acc = sum[ACC_W-1:0];
   end

   always @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         acc <= {ACC_W{1'b0}};
         overflow_out <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         overflow_out <= next_ovf;
      end
   end
endmodule

// ### motrep_regs.v
// Motion report registers: revision, status, X and Y displacement
`timescale 1ns/1ps
`include "motrep_defs.vh"
module motrep_regs #(
   // Arbitrary revision value
   parameter [7:0] SILICON_REVISION = 8'h5a,
   parameter FAULT_FILT = `MR_FAULT_FILT
)(
   input wire clk_sys_in,
   input wire rst_b_in,
   input wire [`MR_ADDR_W-1:0] reg_addr_in,
   input wire reg_rd_in,
   input wire reg_wr_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   output reg reg_rvalid_out,
   input wire motion_valid_in,
   input wire [7:0] motion_dx_in,
   input wire [7:0] motion_dy_in,
   input wire resolution_select_in,
   input wire [7:0] lowpower_cfg_a_in,
   input wire [7:0] lowpower_cfg_b_in,
   input wire bias_resistor_pin_short_in,
   input wire laser_drive_pin_short_in,
   output reg moved_flag_out,
   output reg accum_overflow_flag_out,
   output reg fault_out
);
   localparam CNT_W = 4;
   localparam [CNT_W-1:0] FILT_MAX = FAULT_FILT[CNT_W-1:0];

   wire [15:0] add_bus;
   wire [15:0] take_bus;
   wire [1:0] nz_bus;
   wire [1:0] fs_bus;
   wire [1:0] ov_bus;
   wire status_rd;
   wire dx_rd;
   wire dy_rd;
   wire clear_wr;
   wire lp_ok;
   wire short_seen;
   wire [7:0] status_val;
   reg [1:0] bias_sync;
   reg [1:0] laser_sync;
   reg [CNT_W-1:0] fault_cnt;
   reg fault_flag;
   reg accum_overflow_flag;
   reg [7:0] snap_x;
   reg [7:0] snap_y;
   reg [7:0] next_rdata;
   reg next_ovf_flag;
   reg [7:0] write_seen;

   function is_addr;
      input [`MR_ADDR_W-1:0] a;
      input [`MR_ADDR_W-1:0] ref_a;
      begin
         is_addr = (a == ref_a);
      end
   endfunction

   assign status_rd = reg_rd_in && is_addr(reg_addr_in, `MR_ADDR_STATUS);
   assign dx_rd = reg_rd_in && is_addr(reg_addr_in, `MR_ADDR_DELTA_X);
   assign dy_rd = reg_rd_in && is_addr(reg_addr_in, `MR_ADDR_DELTA_Y);
   assign clear_wr = reg_wr_in &&
      is_addr(reg_addr_in, `MR_ADDR_MOTION_CLEAR);

   assign add_bus = {motion_dy_in, motion_dx_in};

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1)
      begin : g_axis
         motrep_axis #(
            .ACC_W(`MR_ACC_W)
         ) u_axis (
            .clk_sys_in(clk_sys_in),
            .rst_b_in(rst_b_in),
            .add_valid_in(motion_valid_in),
            .add_delta_in(add_bus[i*8 +: 8]),
            .high_res_in(resolution_select_in),
            .clear_in(clear_wr),
            .take_in(status_rd),
            .take_delta_out(take_bus[i*8 +: 8]),
            .nonzero_out(nz_bus[i]),
            .full_scale_out(fs_bus[i]),
            .overflow_out(ov_bus[i])
         );
      end
   endgenerate

   // Pin short inputs synchroniser
   always @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         bias_sync <= 2'h0;
         laser_sync <= 2'h0;
      end
      else
      begin
         bias_sync <= {bias_sync[0], bias_resistor_pin_short_in};
         laser_sync <= {laser_sync[0], laser_drive_pin_short_in};
      end
   end

   assign short_seen = bias_sync[1] | laser_sync[1];

   always @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         fault_cnt <= {CNT_W{1'b0}};
         fault_flag <= 1'b0;
      end
      else
      begin
         if (!short_seen)
            fault_cnt <= {CNT_W{1'b0}};
         else if (fault_cnt != FILT_MAX)
            fault_cnt <= fault_cnt + 1'b1;
         fault_flag <= short_seen && (fault_cnt == FILT_MAX);
      end
   end

   assign lp_ok = (lowpower_cfg_a_in == ~lowpower_cfg_b_in);

   assign status_val = {
      |nz_bus,
      1'b0,
      lp_ok,
      accum_overflow_flag,
      2'h0,
      fault_flag,
      resolution_select_in
   };

   // Overflow flag, set wins
   always @*
   begin
      next_ovf_flag = accum_overflow_flag;
      if ((dx_rd || dy_rd) && !(|fs_bus))
         next_ovf_flag = 1'b0;
      if (clear_wr)
         next_ovf_flag = 1'b0;
      if (|ov_bus)
         next_ovf_flag = 1'b1;
   end

   always @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         accum_overflow_flag <= 1'b0;
      else
         accum_overflow_flag <= next_ovf_flag;
   end

   // Frozen delta snapshots
   always @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         snap_x <= `MR_DELTA_RESET;
         snap_y <= `MR_DELTA_RESET;
      end
      else if (clear_wr)
      begin
         snap_x <= `MR_DELTA_RESET;
         snap_y <= `MR_DELTA_RESET;
      end
      else if (status_rd)
      begin
         snap_x <= take_bus[7:0];
         snap_y <= take_bus[15:8];
      end
      else
      begin
         if (dx_rd)
            snap_x <= `MR_DELTA_RESET;
         if (dy_rd)
            snap_y <= `MR_DELTA_RESET;
      end
   end

   // Read data select
   always @*
   begin
      next_rdata = `MR_READ_ZERO;
      case (reg_addr_in)
         `MR_ADDR_REVISION:
            next_rdata = SILICON_REVISION;
         `MR_ADDR_STATUS:
            next_rdata = status_val;
         `MR_ADDR_DELTA_X:
            next_rdata = snap_x;
         `MR_ADDR_DELTA_Y:
            next_rdata = snap_y;
         default:
            next_rdata = `MR_READ_ZERO;
      endcase
   end

   always @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         reg_rdata_out <= `MR_READ_ZERO;
         reg_rvalid_out <= 1'b0;
      end
      else
      begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in)
            reg_rdata_out <= next_rdata;
      end
   end

   // Last written data, kept for the clear write
   always @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         write_seen <= 8'h00;
      else if (clear_wr)
         write_seen <= reg_wdata_in;
   end

   always @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         moved_flag_out <= 1'b0;
         accum_overflow_flag_out <= 1'b0;
         fault_out <= 1'b0;
      end
      else
      begin
         moved_flag_out <= |nz_bus;
         accum_overflow_flag_out <= accum_overflow_flag;
         fault_out <= fault_flag;
      end
   end
endmodule

// ### motrep_regs_asserts.sv
// Checker for the motion report register port
`timescale 1ns/1ps
`include "motrep_defs.vh"
module motrep_regs_chk #(
   parameter [7:0] SILICON_REVISION = 8'h5a
)(
   input wire clk_sys_in,
   input wire rst_b_in,
   input wire [`MR_ADDR_W-1:0] reg_addr_in,
   input wire reg_rd_in,
   input wire reg_wr_in,
   input wire [7:0] reg_rdata_out,
   input wire reg_rvalid_out,
   input wire motion_valid_in,
   input wire resolution_select_in,
   input wire [7:0] lowpower_cfg_a_in,
   input wire [7:0] lowpower_cfg_b_in,
   input wire moved_flag_out,
   input wire accum_overflow_flag_out
);
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);
   sequence st_rd;
      reg_rd_in && reg_addr_in == `MR_ADDR_STATUS;
   endsequence
   read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read not answered next cycle");
   no_stray_a: assert property (!reg_rd_in |=> !reg_rvalid_out)
      else $error("answer without read");
   revision_val_a: assert property (reg_rd_in &&
      reg_addr_in == `MR_ADDR_REVISION |=> reg_rdata_out == SILICON_REVISION)
      else $error("revision value wrong");
   status_rsvd_a: assert property (st_rd |=>
      reg_rdata_out[6] == 1'b0 && reg_rdata_out[3:2] == 2'b00)
      else $error("reserved status bits set");
   lp_complement_a: assert property (st_rd |=> reg_rdata_out[5] ==
      ($past(lowpower_cfg_a_in) == ~$past(lowpower_cfg_b_in)))
      else $error("complement bit wrong");
   res_bit_a: assert property (st_rd |=>
      reg_rdata_out[0] == $past(resolution_select_in))
      else $error("resolution bit wrong");
   x_clear_read_a: assert property (reg_rd_in &&
      reg_addr_in == `MR_ADDR_DELTA_X ##1 !reg_rd_in ##1 reg_rd_in &&
      reg_addr_in == `MR_ADDR_DELTA_X |=> reg_rdata_out == 8'h00)
      else $error("x delta not cleared by read");
   clear_motion_a: assert property (reg_wr_in &&
      reg_addr_in == `MR_ADDR_MOTION_CLEAR && !motion_valid_in ##1
      !motion_valid_in |=> !moved_flag_out)
      else $error("motion kept after clear");
   cover property (st_rd ##1 reg_rdata_out[7]);
   cover property (reg_wr_in && reg_addr_in == `MR_ADDR_MOTION_CLEAR);
   cover property ($rose(accum_overflow_flag_out));
endmodule

// ### motrep_host.sv
// Host model that reaches the registers one access at a time
`timescale 1ns/1ps
module motrep_host (
   input wire clk_sys_in,
   output logic [6:0] reg_addr_out,
   output logic reg_rd_out,
   output logic reg_wr_out,
   output logic [7:0] reg_wdata_out,
   input wire [7:0] reg_rdata_in,
   input wire reg_rvalid_in
);
   initial
   begin
      reg_addr_out = 7'h7f;
      reg_rd_out = 1'b0;
      reg_wr_out = 1'b0;
      reg_wdata_out = 8'h00;
   end
   task automatic access(input logic [6:0] a, input logic w,
      input logic [7:0] wd, output logic [7:0] rd);
      @(negedge clk_sys_in);
      reg_addr_out = a;
      reg_rd_out = !w;
      reg_wr_out = w;
      reg_wdata_out = wd;
      @(negedge clk_sys_in);
      rd = reg_rvalid_in ? reg_rdata_in : 8'hxx;
      reg_rd_out = 1'b0;
      reg_wr_out = 1'b0;
      reg_addr_out = ~a;
      reg_wdata_out = ~wd;
   endtask
   task automatic report(output logic [7:0] st, x, y);
      access(7'h02, 1'b0, 8'h00, st);
      access(7'h03, 1'b0, 8'h00, x);
      access(7'h04, 1'b0, 8'h00, y);
   endtask
endmodule

// ### motrep_regs_bench.sv
// Testbench for the motion report registers
`timescale 1ns/1ps
`include "motrep_defs.vh"
module motrep_regs_bench;
   // Arbitrary revision value
   localparam [7:0] REV = 8'h3c;
   logic clk_sys_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic mv = 1'b0;
   logic [7:0] dx = 8'h00;
   logic [7:0] dy = 8'h00;
   logic res = 1'b0;
   logic [7:0] cfg_a = 8'h00;
   logic [7:0] cfg_b = 8'h00;
   logic [1:0] sh = 2'b00;
   wire [6:0] addr;
   wire rd, wr, rvalid, moved, ovf, fault;
   wire [7:0] wdata, rdata;
   logic [7:0] st, x, y;
   int err_total = 0;
   int comparisons = 0;
   always #10 clk_sys_in = ~clk_sys_in;
   motrep_regs #(.SILICON_REVISION(REV), .FAULT_FILT(1)) dut (
      .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .motion_valid_in(mv),
      .motion_dx_in(dx), .motion_dy_in(dy),
      .resolution_select_in(res), .lowpower_cfg_a_in(cfg_a),
      .lowpower_cfg_b_in(cfg_b), .bias_resistor_pin_short_in(sh[0]),
      .laser_drive_pin_short_in(sh[1]), .moved_flag_out(moved),
      .accum_overflow_flag_out(ovf), .fault_out(fault));
   motrep_host host (.clk_sys_in(clk_sys_in), .reg_addr_out(addr),
      .reg_rd_out(rd), .reg_wr_out(wr), .reg_wdata_out(wdata),
      .reg_rdata_in(rdata), .reg_rvalid_in(rvalid));
   task automatic chk(input logic [7:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic add(input logic [7:0] ax, ay);
      @(negedge clk_sys_in);
      mv = 1'b1;
      dx = ax;
      dy = ay;
      @(negedge clk_sys_in);
      mv = 1'b0;
   endtask
   task automatic rreg(input logic [6:0] a, input logic [7:0] exp);
      host.access(a, 1'b0, 8'h00, st);
      chk(st, exp);
   endtask
   task automatic t_ident;
      rreg(`MR_ADDR_REVISION, REV);
      host.access(`MR_ADDR_REVISION, 1'b1, 8'h11, st);
      rreg(`MR_ADDR_REVISION, REV);
      rreg(7'h05, 8'h00);
   endtask
   task automatic t_flags;
      cfg_a = 8'h7f;
      cfg_b = 8'h80;
      res = 1'b1;
      rreg(`MR_ADDR_STATUS, 8'h21);
      cfg_b = 8'h7f;
      res = 1'b0;
      rreg(`MR_ADDR_STATUS, 8'h00);
   endtask
   task automatic t_motion;
      add(8'h05, 8'hfd);
      repeat (2) @(negedge clk_sys_in);
      chk(moved, 1'b1);
      host.report(st, x, y);
      chk(st, 8'h80);
      chk(x, 8'h05);
      chk(y, 8'hfd);
      rreg(`MR_ADDR_DELTA_X, 8'h00);
      rreg(`MR_ADDR_DELTA_X, 8'h00);
      rreg(`MR_ADDR_DELTA_Y, 8'h00);
      rreg(`MR_ADDR_STATUS, 8'h00);
   endtask
   task automatic t_refreeze;
      add(8'h03, 8'h00);
      rreg(`MR_ADDR_STATUS, 8'h80);
      add(8'h04, 8'h02);
      rreg(`MR_ADDR_STATUS, 8'h80);
      rreg(`MR_ADDR_DELTA_X, 8'h04);
      rreg(`MR_ADDR_DELTA_Y, 8'h02);
   endtask
   task automatic t_overflow(input logic r);
      int rem;
      int n;
      res = r;
      repeat (r ? 40 : 20) add(8'h7f, 8'h00);
      @(negedge clk_sys_in);
      chk(ovf, 1'b1);
      host.report(st, x, y);
      chk(st, 8'h90 | {7'h00, r});
      chk(x, 8'h7f);
      n = 1;
      rem = (r ? `MR_LIM_POS_HI : `MR_LIM_POS_LO) - 127;
      while (rem > 0 && n < 40)
      begin
         host.report(st, x, y);
         n++;
         chk(st, 8'h80 | {7'h00, r});
         chk(x, rem > 127 ? 8'h7f : 8'(rem));
         rem = rem - (rem > 127 ? 127 : rem);
      end
      chk(8'(n), r ? 8'd32 : 8'd16);
      rreg(`MR_ADDR_STATUS, {7'h00, r});
   endtask
   task automatic t_clear;
      add(8'h40, 8'hc0);
      host.access(`MR_ADDR_MOTION_CLEAR, 1'b1, 8'ha5, st);
      host.report(st, x, y);
      chk(st, 8'h00);
      chk(x, 8'h00);
      chk(y, 8'h00);
   endtask
   task automatic t_fault;
      int n;
      for (int i = 0; i < 2; i++)
      begin
         sh = 2'(1 << i);
         n = 0;
         while (fault !== 1'b1 && n < 20)
         begin
            @(negedge clk_sys_in);
            n++;
         end
         chk({7'h00, fault}, 8'h01);
         rreg(`MR_ADDR_STATUS, 8'h02);
         sh = 2'b00;
         repeat (10) @(negedge clk_sys_in);
         chk({7'h00, fault}, 8'h00);
         rreg(`MR_ADDR_STATUS, 8'h00);
      end
   endtask
   task automatic finish_test;
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge clk_sys_in);
      rst_b_in = 1'b1;
      t_ident();
      t_flags();
      t_motion();
      t_refreeze();
      t_overflow(1'b1);
      t_overflow(1'b0);
      t_clear();
      t_fault();
      finish_test();
   end
   initial
   begin
      #(20 * 5000);
      err_total++;
      finish_test();
   end
endmodule
bind motrep_regs motrep_regs_chk #(.SILICON_REVISION(SILICON_REVISION))
   u_chk (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_rd_in, .reg_wr_in,
   .reg_rdata_out, .reg_rvalid_out, .motion_valid_in,
   .resolution_select_in, .lowpower_cfg_a_in, .lowpower_cfg_b_in,
   .moved_flag_out, .accum_overflow_flag_out);
